// *** hw/lcbs_pkg.sv ***
`default_nettype none
package lcbs_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] SUPPLY_CFG_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h004;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h008;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_HREF_BIT = 2;
  localparam int CFG_BYP_BIT = 3;
  localparam int CFG_PUMP_BIT = 4;
  localparam int CFG_REG_BIT = 5;
  localparam int CTRL_DISP_BIT = 0;
  localparam int CTRL_CPEN_BIT = 1;
  localparam int ST_SW1_BIT = 0;
  localparam int ST_SW2_BIT = 1;
  localparam int ST_SW3_BIT = 2;
  localparam int ST_BUF_BIT = 3;
  localparam int ST_BLANK_BIT = 4;
  localparam int ST_SEG_BIT = 5;

  // ------------------------------------------------------------
  // Supply source codes and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_SW_ONE = 2'h0;
  localparam logic [1:0] SEL_SW_TWO = 2'h1;
  localparam logic [1:0] SEL_SW_THREE = 2'h2;
  localparam logic [1:0] SEL_RESET = SEL_SW_TWO;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // ------------------------------------------------------------
  // Blanking after the pump is switched on, in timebase cycles
  // ------------------------------------------------------------
  localparam int BLANK_CYCLES = 16;
  localparam int BLANK_CNT_W = 5;
  localparam logic [BLANK_CNT_W-1:0] BLANK_LOAD = BLANK_CNT_W'(BLANK_CYCLES - 1);
  localparam logic [BLANK_CNT_W-1:0] BLANK_ZERO = '0;

  // Switch vector {one, two, three} for a supply source code
  function automatic logic [2:0] lcbs_decode(input logic [1:0] sel);
    logic [2:0] sw;
    sw = 3'h0;
    if (sel == SEL_SW_ONE) begin
      sw = 3'h4;
    end else if (sel == SEL_SW_TWO) begin
      sw = 3'h2;
    end else if (sel == SEL_SW_THREE) begin
      sw = 3'h1;
    end
    return sw;
  endfunction

endpackage
`default_nettype wire

// *** hw/lcbs_blank_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface lcbs_blank_if;
  logic start;
  logic blanking;
  modport ctrl (output start, input blanking);
  modport timer (input start, output blanking);
endinterface
`default_nettype wire

// *** hw/lcbs_blank_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcbs_blank_timer
  import lcbs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to the controller
  lcbs_blank_if.timer bl
);

  typedef struct packed {
    logic [BLANK_CNT_W-1:0] cnt;
    logic blanking;
  } lcbs_timer_st_t;

  lcbs_timer_st_t st_q;
  lcbs_timer_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (bl.start) begin
      // A fresh set restarts the full window
      st_d.cnt = BLANK_LOAD;
      st_d.blanking = 1'b1;
    end else if (st_q.blanking) begin
      if (st_q.cnt == BLANK_ZERO) begin
        st_d.blanking = 1'b0;
      end else begin
        st_d.cnt = st_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bl.blanking = st_q.blanking;

  // Cycles since the last start, counting to 16 and then clearing to zero, kept apart from the timer's own count
  logic [BLANK_CNT_W-1:0] age_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= BLANK_ZERO;
    end else if (bl.start) begin
      age_q <= BLANK_CNT_W'(1);
    end else if (age_q == BLANK_CNT_W'(BLANK_CYCLES)) begin
      age_q <= BLANK_ZERO;
    end else if (age_q != BLANK_ZERO) begin
      age_q <= age_q + BLANK_CNT_W'(1);
    end
  end

  property p_blank_window;
    @(posedge pclk) disable iff (!presetn)
    age_q == BLANK_CNT_W'(BLANK_CYCLES) && !bl.start |=> !bl.blanking;
  endproperty
  a_blank_window: assert property (p_blank_window)
    else $error("blanking does not end exactly 16 cycles after start");

  property p_blank_hold;
    @(posedge pclk) disable iff (!presetn)
    bl.start |=> bl.blanking [*8] ##1 bl.blanking [*8];
  endproperty
  a_blank_hold: assert property (p_blank_hold)
    else $error("blanking dropped inside the 16 cycle window");

endmodule
`default_nettype wire

// *** hw/lcbs_top.sv ***
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lcbs_top
  import lcbs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply switches, buffer, divider, pump, resistor and regulator controls
  output logic supply_switch_one,
  output logic supply_switch_two,
  output logic supply_switch_three,
  output logic buffer_enable,
  output logic divider_two_thirds_close,
  output logic divider_bypass,
  output logic pump_run,
  output logic resistor_bias_run,
  output logic top_level_external,
  output logic regulator_run,
  // Segment and common drivers
  output logic seg_com_enable
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] supply_source_select;
    logic high_reference_select;
    logic buffer_bypass;
    logic pump_or_resistor_select;
    logic regulator_enable;
    logic display_enable;
    logic charge_pump_enable;
    logic [2:0] sw;
    logic buf_en;
    logic div_close;
    logic div_byp;
    logic pump;
    logic res;
    logic top_ext;
    logic reg_run;
    logic seg_en;
    logic [31:0] rdata;
    logic slverr;
  } lcbs_top_st_t;

  lcbs_top_st_t st_q;
  lcbs_top_st_t st_d;
  lcbs_blank_if bl ();

  logic wr_acc;
  logic setup;
  logic cpen_set;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign cpen_set = wr_acc && (paddr == CTRL_ADDR) && pwdata[CTRL_CPEN_BIT]
    && !st_q.charge_pump_enable;
  assign bl.start = cpen_set;

  lcbs_blank_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .bl(bl)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (wr_acc) begin
      if (paddr == SUPPLY_CFG_ADDR) begin
        // Combinations outside the supported set are stored as written
        st_d.supply_source_select = pwdata[CFG_SEL_LSB +: 2];
        st_d.high_reference_select = pwdata[CFG_HREF_BIT];
        st_d.buffer_bypass = pwdata[CFG_BYP_BIT];
        st_d.pump_or_resistor_select = pwdata[CFG_PUMP_BIT];
        st_d.regulator_enable = pwdata[CFG_REG_BIT];
      end else if (paddr == CTRL_ADDR) begin
        st_d.display_enable = pwdata[CTRL_DISP_BIT];
        st_d.charge_pump_enable = pwdata[CTRL_CPEN_BIT];
      end
    end
    // Outputs follow the stored bits one edge later
    st_d.sw = lcbs_decode(st_q.supply_source_select);
    st_d.buf_en = !st_q.buffer_bypass
      && (st_q.supply_source_select == SEL_SW_THREE);
    st_d.div_close = !st_q.high_reference_select;
    st_d.div_byp = st_q.high_reference_select;
    st_d.pump = st_q.pump_or_resistor_select;
    st_d.res = !st_q.pump_or_resistor_select;
    st_d.top_ext = !st_q.pump_or_resistor_select;
    st_d.reg_run = st_q.regulator_enable;
    // Start pulse is included so no enabled cycle slips through
    st_d.seg_en = st_q.display_enable && !bl.blanking && !cpen_set;
    // Read data and error are prepared in the setup phase
    if (setup) begin
      st_d.rdata = RDATA_RESET;
      st_d.slverr = 1'b0;
      if (paddr == SUPPLY_CFG_ADDR) begin
        st_d.rdata[CFG_SEL_LSB +: 2] = st_q.supply_source_select;
        st_d.rdata[CFG_HREF_BIT] = st_q.high_reference_select;
        st_d.rdata[CFG_BYP_BIT] = st_q.buffer_bypass;
        st_d.rdata[CFG_PUMP_BIT] = st_q.pump_or_resistor_select;
        st_d.rdata[CFG_REG_BIT] = st_q.regulator_enable;
      end else if (paddr == CTRL_ADDR) begin
        st_d.rdata[CTRL_DISP_BIT] = st_q.display_enable;
        st_d.rdata[CTRL_CPEN_BIT] = st_q.charge_pump_enable;
      end else if (paddr == STATUS_ADDR) begin
        st_d.rdata[ST_SW1_BIT] = st_q.sw[2];
        st_d.rdata[ST_SW2_BIT] = st_q.sw[1];
        st_d.rdata[ST_SW3_BIT] = st_q.sw[0];
        st_d.rdata[ST_BUF_BIT] = st_q.buf_en;
        st_d.rdata[ST_BLANK_BIT] = bl.blanking;
        st_d.rdata[ST_SEG_BIT] = st_q.seg_en;
      end else begin
        st_d.slverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.supply_source_select <= SEL_RESET;
      st_q.sw <= lcbs_decode(SEL_RESET);
      st_q.div_close <= 1'b1;
      st_q.res <= 1'b1;
      st_q.top_ext <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Zero wait states keep the slave simple; nothing here needs to stall
  assign pready = 1'b1;
  assign prdata = st_q.rdata;
  assign pslverr = st_q.slverr;
  assign supply_switch_one = st_q.sw[2];
  assign supply_switch_two = st_q.sw[1];
  assign supply_switch_three = st_q.sw[0];
  assign buffer_enable = st_q.buf_en;
  assign divider_two_thirds_close = st_q.div_close;
  assign divider_bypass = st_q.div_byp;
  assign pump_run = st_q.pump;
  assign resistor_bias_run = st_q.res;
  assign top_level_external = st_q.top_ext;
  assign regulator_run = st_q.reg_run;
  assign seg_com_enable = st_q.seg_en;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic after_rst_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      after_rst_q <= 1'b0;
    end else begin
      after_rst_q <= 1'b1;
    end
  end

  property p_sel_decode;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> {supply_switch_one, supply_switch_two, supply_switch_three}
      == lcbs_decode($past(st_q.supply_source_select));
  endproperty
  a_sel_decode: assert property (p_sel_decode)
    else $error("switch outputs do not match the supply source code");

  property p_reset_value;
    @(posedge pclk) disable iff (!presetn)
    !after_rst_q |-> st_q.supply_source_select == SEL_RESET
      && supply_switch_two && !supply_switch_one && !supply_switch_three;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("reset supply source is not switch two");

  property p_buffer;
    @(posedge pclk) disable iff (!presetn)
    buffer_enable |-> supply_switch_three && !$past(st_q.buffer_bypass);
  endproperty
  a_buffer: assert property (p_buffer)
    else $error("buffer enabled while bypassed or switch three off");

  property p_blank_outputs;
    @(posedge pclk) disable iff (!presetn)
    bl.start |=> !seg_com_enable [*8] ##1 !seg_com_enable [*8];
  endproperty
  a_blank_outputs: assert property (p_blank_outputs)
    else $error("segment outputs enabled during pump start window");

  property p_divider_close;
    @(posedge pclk) disable iff (!presetn)
    !st_q.high_reference_select |=> divider_two_thirds_close && !divider_bypass;
  endproperty
  a_divider_close: assert property (p_divider_close)
    else $error("two-thirds divider not closed for high reference 0");

  property p_divider_bypass;
    @(posedge pclk) disable iff (!presetn)
    st_q.high_reference_select |=> divider_bypass && !divider_two_thirds_close;
  endproperty
  a_divider_bypass: assert property (p_divider_bypass)
    else $error("divider not bypassed for high reference 1");

  property p_pump;
    @(posedge pclk) disable iff (!presetn)
    st_q.pump_or_resistor_select |=> pump_run && !resistor_bias_run;
  endproperty
  a_pump: assert property (p_pump)
    else $error("charge pump not selected");

  property p_resistor;
    @(posedge pclk) disable iff (!presetn)
    !st_q.pump_or_resistor_select |=> resistor_bias_run && top_level_external
      && !pump_run;
  endproperty
  a_resistor: assert property (p_resistor)
    else $error("resistor network not selected");

  property p_registered;
    @(posedge pclk) disable iff (!presetn)
    $changed(st_q.supply_source_select) |->
      {supply_switch_one, supply_switch_two, supply_switch_three}
      == lcbs_decode($past(st_q.supply_source_select)) ##1
      {supply_switch_one, supply_switch_two, supply_switch_three}
      == lcbs_decode($past(st_q.supply_source_select));
  endproperty
  a_registered: assert property (p_registered)
    else $error("switches did not follow a selector change one cycle later");

endmodule
`default_nettype wire

// *** dv/lcd_bias_supply_config_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module lcd_bias_supply_config_tb
  import lcbs_pkg::*;
;
  // ----------------------------------------
  // Clock, reset and ports
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, sw1, sw2, sw3, buf_en, div_cl, div_by;
  logic pump, res, ext, regr, seg;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  always #25 pclk = ~pclk;

  lcbs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supply_switch_one(sw1), .supply_switch_two(sw2),
    .supply_switch_three(sw3), .buffer_enable(buf_en), .divider_two_thirds_close(div_cl),
    .divider_bypass(div_by), .pump_run(pump), .resistor_bias_run(res),
    .top_level_external(ext), .regulator_run(regr), .seg_com_enable(seg));

  // ----------------------------------------
  // Bus and closing tasks
  // ----------------------------------------
  // Returns just after the edge that took the transfer
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a stalled wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    `CHK("reset switches", 3'h2, {sw1, sw2, sw3})
    `CHK("reset outputs", 7'h26, {buf_en, div_cl, div_by, pump, res, ext, regr})
    `CHK("reset seg", 1'b0, seg)
    apb(1'b0, SUPPLY_CFG_ADDR, 32'h0000_0000, r, e);
    `CHK("reset cfg", 32'h0000_0001, r)
    apb(1'b0, STATUS_ADDR, 32'h0000_0000, r, e);
    `CHK("reset status", 32'h0000_0002, r)
  endtask

  // Supported supply combinations plus code 3, which turns every switch off; every code and mode bit is still reached
  // Bias mode lives outside this block; the pump settings assume one-third bias
  localparam int N_CFGS = 12;
  localparam logic [6*N_CFGS-1:0] LEGAL_CFGS = {
    6'h37, 6'h33, 6'h07, 6'h03,
    6'h17, 6'h13, 6'h1e, 6'h12,
    6'h15, 6'h11, 6'h14, 6'h10};

  task automatic t_config();
    logic [31:0] c, r;
    logic e;
    logic [1:0] s;
    logic [2:0] prev;
    int i;
    prev = 3'h2;
    for (i = 0; i < N_CFGS; i++) begin
      c = 32'(LEGAL_CFGS[i*6 +: 6]);
      s = c[1:0];
      apb(1'b1, SUPPLY_CFG_ADDR, c, r, e);
      #1;
      `CHK("switches before update", prev, {sw1, sw2, sw3})
      @(posedge pclk);
      #1;
      prev = {s == 2'h0, s == 2'h1, s == 2'h2};
      `CHK("switches", prev, {sw1, sw2, sw3})
      `CHK("buffer", !c[CFG_BYP_BIT] && s == 2'h2, buf_en)
      `CHK("div close", !c[CFG_HREF_BIT], div_cl)
      `CHK("div bypass", c[CFG_HREF_BIT], div_by)
      `CHK("pump", c[CFG_PUMP_BIT], pump)
      `CHK("resistor", !c[CFG_PUMP_BIT], res)
      `CHK("external top", !c[CFG_PUMP_BIT], ext)
      `CHK("regulator", c[CFG_REG_BIT], regr)
      apb(1'b0, SUPPLY_CFG_ADDR, 32'h0000_0000, r, e);
      `CHK("cfg read", c, r)
      apb(1'b0, STATUS_ADDR, 32'h0000_0000, r, e);
      `CHK("status", {!c[CFG_BYP_BIT] && s == 2'h2, prev[0], prev[1], prev[2]}, r[3:0])
    end
  endtask

  task automatic t_blank();
    logic [31:0] r;
    logic e;
    int k;
    apb(1'b1, CTRL_ADDR, 32'h0000_0001, r, e);
    @(posedge pclk);
    @(posedge pclk);
    #1;
    `CHK("seg on", 1'b1, seg)
    apb(1'b1, CTRL_ADDR, 32'h0000_0003, r, e);
    for (k = 1; k <= 16; k++) begin
      @(posedge pclk);
      #1;
      `CHK("seg blanked", 1'b0, seg)
    end
    @(posedge pclk);
    #1;
    `CHK("seg after blank", 1'b1, seg)
    apb(1'b1, CTRL_ADDR, 32'h0000_0003, r, e);
    @(posedge pclk);
    #1;
    `CHK("no restart", 1'b1, seg)
    // Pump enable with the display off still blanks
    apb(1'b1, CTRL_ADDR, 32'h0000_0000, r, e);
    apb(1'b1, CTRL_ADDR, 32'h0000_0002, r, e);
    apb(1'b0, STATUS_ADDR, 32'h0000_0000, r, e);
    `CHK("status blanking", 2'h1, r[5:4])
    apb(1'b1, CTRL_ADDR, 32'h0000_0003, r, e);
    @(posedge pclk);
    #1;
    `CHK("seg still blanked", 1'b0, seg)
    repeat (20) @(posedge pclk);
    apb(1'b0, STATUS_ADDR, 32'h0000_0000, r, e);
    `CHK("status done", 2'h2, r[5:4])
  endtask

  task automatic t_unmapped();
    logic [31:0] r;
    logic e;
    apb(1'b1, 12'h00c, 32'hffff_ffff, r, e);
    `CHK("write err", 1'b1, e)
    apb(1'b0, 12'h00c, 32'h0000_0000, r, e);
    `CHK("read err", 1'b1, e)
    `CHK("read data", 32'h0000_0000, r)
    apb(1'b0, SUPPLY_CFG_ADDR, 32'h0000_0000, r, e);
    `CHK("cfg kept", 32'h0000_0037, r)
    `CHK("mapped err", 1'b0, e)
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    t_reset();
    t_config();
    t_unmapped();
    t_blank();
    // Reset in mid-run returns to the core supply setting
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    `CHK("second reset", 3'h2, {sw1, sw2, sw3})
    @(posedge pclk);
    presetn <= 1'b1;
    #1;
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
